// ### core/ilvf_irq_lvd.v
`timescale 1ns/1ps
`include "ilvf_consts.vh"
module ilvf_irq_lvd #(
   parameter LVD_DLY = `ILVF_LVD_DLY_CYC
) (
   input  wire       clk_sys,
   input  wire       sys_rst,
   input  wire [7:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   input  wire [3:0] ext_irq_pins,
   input  wire       thermal_event,
   input  wire [9:0] internal_events,
   input  wire       lowvolt_compare,
   input  wire       sleep_mode,
   input  wire       idle_mode,
   input  wire       lvr_enable,
   input  wire       stack_full,
   input  wire       irq_ack,
   output reg        irq_req,
   output reg  [3:0] irq_vector,
   output wire       detector_power,
   output wire [2:0] lowvolt_threshold_select,
   output wire       bandgap_enable,
   output wire       wake_request
);
   // ****************************************
   // Registers
   // ****************************************
   reg  [7:0] lowvolt_detect_control_q;
   reg  [7:0] irq_edge_select_q;
   reg  [7:0] irq_control_0_q;
   reg  [7:0] irq_control_1_q;
   reg  [7:0] irq_control_2_q;
   reg  [7:0] multifunc_irq_0_q;
   reg  [7:0] multifunc_irq_1_q;
   reg  [3:0] pin_s1_q;
   reg  [3:0] pin_s2_q;
   reg  [3:0] pin_prev_q;
   reg  [3:0] pin_hit_q;
   reg        lowvolt_output_flag_q;
   reg  [15:0] lvd_cnt_q;
   reg        lvd_fire_q;
   wire [7:0] ic0_d;
   wire [7:0] ic1_d;
   wire [7:0] ic2_d;
   wire [7:0] mf0_d;
   wire [7:0] mf1_d;
   wire [3:0] pin_edge;
   wire [10:0] pend;
   wire       gie;
   wire [3:0] pin_flag;

   // Edge qualification per pin, shared by all four pins.
   function edge_ok;
      input [1:0] sel;
      input       prev;
      input       cur;
      begin
         case (sel)
            `ILVF_EDGE_RISE: edge_ok = ~prev & cur;
            `ILVF_EDGE_FALL: edge_ok = prev & ~cur;
            `ILVF_EDGE_BOTH: edge_ok = prev ^ cur;
            default:         edge_ok = 1'b0;
         endcase
      end
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         assign pin_edge[gi] = edge_ok(irq_edge_select_q[2*gi+1:2*gi],
                                       pin_prev_q[gi], pin_s2_q[gi]);
      end
   endgenerate

   // ****************************************
   // Low voltage detector
   // ****************************************
   // Sleep overrides the enable so the comparator draws no current.
   assign detector_power = lowvolt_detect_control_q[`ILVF_LOWVOLT_DETECT_CONTROL_EN] & ~sleep_mode;
   assign lowvolt_threshold_select = lowvolt_detect_control_q[2:0];
   assign bandgap_enable = detector_power | lvr_enable |
                           lowvolt_detect_control_q[`ILVF_LOWVOLT_DETECT_CONTROL_BG];

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lowvolt_output_flag_q <= 1'b0;
         lvd_cnt_q <= 16'h0000;
         lvd_fire_q <= 1'b0;
      end else begin
         lowvolt_output_flag_q <= detector_power & lowvolt_compare;
         lvd_fire_q <= 1'b0;
         // A drop of the output restarts the delay, so chatter never fires early.
         if (!lowvolt_output_flag_q) begin
            lvd_cnt_q <= 16'h0000;
         end else if (lvd_cnt_q < LVD_DLY[15:0]) begin
            lvd_cnt_q <= lvd_cnt_q + 16'h0001;
            lvd_fire_q <= (lvd_cnt_q == LVD_DLY[15:0] - 16'h0001);
         end
      end
   end

   // ****************************************
   // Pin synchronisers
   // ****************************************
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
         pin_prev_q <= 4'h0;
         pin_hit_q <= 4'h0;
      end else begin
         pin_s1_q <= ext_irq_pins;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
         pin_hit_q <= pin_edge;
      end
   end

   // ****************************************
   // Arbitration
   // ****************************************
   assign gie = irq_control_0_q[`ILVF_IC0_GIE];
   assign pin_flag = {irq_control_1_q[6:4], irq_control_0_q[`ILVF_IC0_P0F]};
   // Priority order: pin0, thermal, low voltage, pins 1..3, mf0, mf1, tb0, tb1, eeprom.
   assign pend[0]  = pin_flag[0] & irq_control_0_q[`ILVF_IC0_P0E];
   assign pend[1]  = irq_control_0_q[4] & irq_control_0_q[1];
   assign pend[2]  = irq_control_0_q[5] & irq_control_0_q[2];
   assign pend[3]  = pin_flag[1] & irq_control_1_q[0];
   assign pend[4]  = pin_flag[2] & irq_control_1_q[1];
   assign pend[5]  = pin_flag[3] & irq_control_1_q[2];
   assign pend[6]  = irq_control_1_q[7] & irq_control_1_q[3];
   assign pend[7]  = irq_control_2_q[4] & irq_control_2_q[0];
   assign pend[8]  = irq_control_2_q[5] & irq_control_2_q[1];
   assign pend[9]  = irq_control_2_q[6] & irq_control_2_q[2];
   assign pend[10] = irq_control_2_q[7] & irq_control_2_q[3];

   integer k;
   always @* begin
      irq_req = gie & ~stack_full & (|pend);
      irq_vector = 4'h0;
      for (k = 10; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            irq_vector = k[3:0];
         end
      end
   end

   // A low voltage flag already set when the delayed detector output fires suppresses the wake-up.
   assign wake_request = (idle_mode | sleep_mode) & lvd_fire_q &
                         ~irq_control_0_q[`ILVF_IC0_LVF];

   // ****************************************
   // Flag update: hardware set wins over software clear
   // ****************************************
   // Write strobe for one register address; every register below uses it.
   function wr_sel;
      input       wr;
      input [7:0] addr;
      input [7:0] target;
      begin
         wr_sel = wr & (addr == target);
      end
   endfunction

   wire       take;
   wire       wlv;
   wire       wed;
   wire       wr0;
   wire       wr1;
   wire       wr2;
   wire       wm0;
   wire       wm1;
   wire [7:0] ic0_base;
   wire [7:0] ic0_srv;
   wire [7:0] ic0_set;
   wire [7:0] ic1_set;
   wire [7:0] ic2_set;
   wire [7:0] mf0_set;
   wire [7:0] mf1_set;

   assign take = irq_req & irq_ack;
   assign wlv = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_LOWVOLT_DETECT_CONTROL);
   assign wed = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_EDGE);
   assign wr0 = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_IC0);
   assign wr1 = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_IC1);
   assign wr2 = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_IC2);
   assign wm0 = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_MF0);
   assign wm1 = wr_sel(reg_wr, reg_addr, `ILVF_ADDR_MF1);

   // Hardware events are ORed in after any software write, so they are never lost.
   assign ic0_set = {1'b0, pin_hit_q[0], lvd_fire_q, thermal_event, 4'h0};
   assign ic1_set = {(|multifunc_irq_0_q[5:4]), pin_hit_q[3:1], 4'h0};
   assign ic2_set = {internal_events[9:7], (|multifunc_irq_1_q[6:4]), 4'h0};
   assign mf0_set = {2'h0, internal_events[1:0], 4'h0};
   assign mf1_set = {1'b0, internal_events[4:2], 4'h0};

   assign ic0_base = wr0 ? (reg_wdata & `ILVF_MASK_IC0) : irq_control_0_q;
   assign ic0_srv = take ? (ic0_base & ~{2'h0, (irq_vector == 4'h2), (irq_vector == 4'h1),
                                        3'h0, 1'b1}) : ic0_base;
   assign ic0_d = ic0_srv | ic0_set;
   assign ic1_d = (wr1 ? reg_wdata : irq_control_1_q) | ic1_set;
   assign ic2_d = (wr2 ? reg_wdata : irq_control_2_q) | ic2_set;
   assign mf0_d = ((wm0 ? reg_wdata : multifunc_irq_0_q) | mf0_set) & `ILVF_MASK_MF0;
   assign mf1_d = ((wm1 ? reg_wdata : multifunc_irq_1_q) | mf1_set) & `ILVF_MASK_MF1;

   // ****************************************
   // Control registers
   // ****************************************
   // The output flag is masked off here, so software can never write it.
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lowvolt_detect_control_q <= `ILVF_RST_VAL;
      end else if (wlv) begin
         lowvolt_detect_control_q <= reg_wdata & `ILVF_MASK_LOWVOLT_DETECT_CONTROL;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_edge_select_q <= `ILVF_RST_VAL;
      end else if (wed) begin
         irq_edge_select_q <= reg_wdata;
      end
   end

   // ****************************************
   // Request flag registers
   // ****************************************
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_control_0_q <= `ILVF_RST_VAL;
      end else begin
         irq_control_0_q <= ic0_d;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_control_1_q <= `ILVF_RST_VAL;
      end else begin
         irq_control_1_q <= ic1_d;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_control_2_q <= `ILVF_RST_VAL;
      end else begin
         irq_control_2_q <= ic2_d;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         multifunc_irq_0_q <= `ILVF_RST_VAL;
      end else begin
         multifunc_irq_0_q <= mf0_d;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         multifunc_irq_1_q <= `ILVF_RST_VAL;
      end else begin
         multifunc_irq_1_q <= mf1_d;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always @* begin
      if (reg_addr == `ILVF_ADDR_LOWVOLT_DETECT_CONTROL) begin
         reg_rdata = {2'h0, lowvolt_output_flag_q, lowvolt_detect_control_q[4:0]};
      end else if (reg_addr == `ILVF_ADDR_EDGE) begin
         reg_rdata = irq_edge_select_q;
      end else if (reg_addr == `ILVF_ADDR_IC0) begin
         reg_rdata = irq_control_0_q;
      end else if (reg_addr == `ILVF_ADDR_IC1) begin
         reg_rdata = irq_control_1_q;
      end else if (reg_addr == `ILVF_ADDR_IC2) begin
         reg_rdata = irq_control_2_q;
      end else if (reg_addr == `ILVF_ADDR_MF0) begin
         reg_rdata = multifunc_irq_0_q;
      end else if (reg_addr == `ILVF_ADDR_MF1) begin
         reg_rdata = multifunc_irq_1_q;
      end else begin
         reg_rdata = 8'h00;
      end
   end
endmodule

// ### include/ilvf_consts.vh
`ifndef ILVF_CONSTS_VH
`define ILVF_CONSTS_VH
// ****************************************
// Register addresses in the special purpose space
// ****************************************
`define ILVF_ADDR_LOWVOLT_DETECT_CONTROL   8'h00
`define ILVF_ADDR_EDGE   8'h01
`define ILVF_ADDR_IC0    8'h02
`define ILVF_ADDR_IC1    8'h03
`define ILVF_ADDR_IC2    8'h04
`define ILVF_ADDR_MF0    8'h05
`define ILVF_ADDR_MF1    8'h06
// ****************************************
// Field positions
// ****************************************
`define ILVF_IC0_GIE     0
`define ILVF_IC0_THE     1
`define ILVF_IC0_LVE     2
`define ILVF_IC0_P0E     3
`define ILVF_IC0_THF     4
`define ILVF_IC0_LVF     5
`define ILVF_IC0_P0F     6
`define ILVF_LOWVOLT_DETECT_CONTROL_OUT    5
`define ILVF_LOWVOLT_DETECT_CONTROL_EN     4
`define ILVF_LOWVOLT_DETECT_CONTROL_BG     3
// ****************************************
// Edge select codes, reset values, masks
// ****************************************
`define ILVF_EDGE_OFF    2'h0
`define ILVF_EDGE_RISE   2'h1
`define ILVF_EDGE_FALL   2'h2
`define ILVF_EDGE_BOTH   2'h3
`define ILVF_RST_VAL     8'h00
`define ILVF_MASK_LOWVOLT_DETECT_CONTROL   8'h1f
`define ILVF_MASK_IC0    8'h7f
`define ILVF_MASK_MF0    8'h33
`define ILVF_MASK_MF1    8'h77
// ****************************************
// Timing
// ****************************************
`define ILVF_CLK_NS      20
`define ILVF_LVD_DLY_NS  120
`define ILVF_LVD_DLY_CYC ((`ILVF_LVD_DLY_NS + `ILVF_CLK_NS - 1) / `ILVF_CLK_NS)
`endif

// ### test/ilvf_chk_assertions.sv
`timescale 1ns/1ps
module ilvf_chk #(
   parameter LVD_DLY = 6
) (
   input wire       clk_sys,
   input wire       sys_rst,
   input wire [7:0] reg_addr,
   input wire       reg_wr,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire       lowvolt_compare,
   input wire       sleep_mode,
   input wire       lvr_enable,
   input wire       stack_full,
   input wire       irq_ack,
   input wire       irq_req,
   input wire       detector_power,
   input wire [2:0] lowvolt_threshold_select,
   input wire       bandgap_enable,
   input wire       wake_request
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_low; detector_power && lowvolt_compare && reg_addr == 8'h00 ##1
      detector_power && reg_addr == 8'h00; endsequence
   property p_stack; stack_full |-> !irq_req; endproperty
   a_stack: assert property (p_stack) else $error("request while stack full");
   property p_sleep; sleep_mode |-> !detector_power; endproperty
   a_sleep: assert property (p_sleep) else $error("detector on in sleep");
   property p_bgap; detector_power || lvr_enable |-> bandgap_enable; endproperty
   a_bgap: assert property (p_bgap) else $error("bandgap off");
   property p_thr; reg_wr && reg_addr == 8'h00 |=>
      {5'h00, lowvolt_threshold_select} == ($past(reg_wdata) & 8'h07); endproperty
   a_thr: assert property (p_thr) else $error("threshold not taken");
   property p_ic0; reg_addr == 8'h02 |-> !reg_rdata[7]; endproperty
   a_ic0: assert property (p_ic0) else $error("control 0 bit 7 set");
   property p_serv; irq_req && irq_ack && !reg_wr |=> !irq_req; endproperty
   a_serv: assert property (p_serv) else $error("request after service");
   property p_wake; wake_request |=> !wake_request; endproperty
   a_wake: assert property (p_wake) else $error("wake pulse too long");
   property p_out; s_low |-> reg_rdata[5]; endproperty
   a_out: assert property (p_out) else $error("output flag low");
endmodule
bind ilvf_irq_lvd ilvf_chk #(.LVD_DLY(LVD_DLY)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .lowvolt_compare(lowvolt_compare), .sleep_mode(sleep_mode), .lvr_enable(lvr_enable),
   .stack_full(stack_full), .irq_ack(irq_ack), .irq_req(irq_req),
   .detector_power(detector_power), .lowvolt_threshold_select(lowvolt_threshold_select),
   .bandgap_enable(bandgap_enable), .wake_request(wake_request));

// ### test/ilvf_core_model.sv
`timescale 1ns/1ps
module ilvf_core_model #(
   parameter WAIT = 2
) (
   input  wire clk_sys,
   input  wire sys_rst,
   input  wire irq_req,
   input  wire ack_on,
   output reg  irq_ack
);
   reg [1:0] wait_q;
   // A slow core lets the request stand a while, so the hold is exercised.
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst || irq_ack || !irq_req || !ack_on) begin
         irq_ack <= 1'b0;
         wait_q <= 2'h0;
      end else if (wait_q == WAIT) begin
         irq_ack <= 1'b1;
      end else begin
         wait_q <= wait_q + 2'h1;
      end
   end
endmodule

// ### test/test_interrupt_and_lowvolt_flags.sv
`timescale 1ns/1ps
module test_interrupt_and_lowvolt_flags;
   localparam DLY = 3;
   localparam [63:0] RB = 64'h00_77_33_ff_ff_7f_ff_1f;
   reg        clk_sys = 1'b0, sys_rst = 1'b1, wr = 1'b0, therm = 1'b0, cmpv = 1'b0;
   reg        sleep = 1'b0, idle = 1'b0, low_voltage_reset = 1'b0, full = 1'b0, ack_on = 1'b0;
   reg  [7:0] addr = 8'h00, wdat = 8'h00, fb;
   reg  [3:0] pins = 4'h0;
   reg  [9:0] evts = 10'h000;
   wire [7:0] rdat;
   wire [3:0] vec;
   wire [2:0] thr;
   wire       req, ack, pwr, bg, wake;
   integer    fails = 0, checks = 0, cyc = 0, wakes = 0, i, j, k;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (wake)
         wakes = wakes + 1;
      if (cyc == 4000) begin
         fails = fails + 1;
         print_verdict;
      end
   end
   ilvf_irq_lvd #(.LVD_DLY(DLY)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(addr),
      .reg_wr(wr), .reg_wdata(wdat), .reg_rdata(rdat), .ext_irq_pins(pins),
      .thermal_event(therm), .internal_events(evts), .lowvolt_compare(cmpv),
      .sleep_mode(sleep), .idle_mode(idle), .lvr_enable(low_voltage_reset), .stack_full(full),
      .irq_ack(ack), .irq_req(req), .irq_vector(vec), .detector_power(pwr),
      .lowvolt_threshold_select(thr), .bandgap_enable(bg), .wake_request(wake));
   ilvf_core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .irq_req(req),
      .ack_on(ack_on), .irq_ack(ack));
   task cmp(input [7:0] got, input [7:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wrr(input [7:0] a, input [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task rd(input [7:0] a, input [7:0] m, input [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      tick(0);
      cmp(rdat & m, e);
   endtask
   task t_regs;
      for (i = 0; i < 8; i = i + 1)
         rd(i[7:0], 8'hff, 8'h00);
      for (i = 0; i < 8; i = i + 1)
         wrr(i[7:0], 8'hff);
      for (i = 0; i < 8; i = i + 1)
         rd(i[7:0], 8'hff, RB[8 * i +: 8]);
      // Cleared from the top down so that no group flag is set again.
      for (i = 7; i >= 0; i = i - 1)
         wrr(i[7:0], 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         wrr(8'h00, i[7:0]);
         tick(0);
         cmp({5'h00, thr}, i[7:0]);
      end
   endtask
   task t_edges;
      for (i = 0; i < 4; i = i + 1) begin
         fb = (i == 0) ? 8'h40 : 8'h08 << i;
         for (k = 0; k < 4; k = k + 1)
            for (j = 0; j < 2; j = j + 1) begin
               wrr(8'h01, k[7:0] << (2 * i));
               @(posedge clk_sys);
               pins[i] <= ~pins[i];
               tick(4);
               rd((i == 0) ? 8'h02 : 8'h03, fb, k[j] ? fb : 8'h00);
               wrr((i == 0) ? 8'h02 : 8'h03, 8'h00);
            end
      end
   endtask
   task t_lowvolt;
      wrr(8'h00, 8'h10);
      low_voltage_reset <= 1'b1;
      idle <= 1'b1;
      addr <= 8'h02;
      tick(4);
      @(posedge clk_sys);
      cmpv <= 1'b1;
      tick(DLY);
      cmp(rdat & 8'h20, 8'h00);
      tick(2);
      cmp(rdat & 8'h20, 8'h20);
      cmp({7'h00, bg}, 8'h01);
      cmp(wakes[7:0], 8'h01);
      rd(8'h00, 8'h20, 8'h20);
      tick(2);
      @(posedge clk_sys);
      cmpv <= 1'b0;
      tick(2);
      wrr(8'h02, 8'h00);
      for (k = 0; k < 4 * DLY; k = k + 1) begin
         @(posedge clk_sys);
         cmpv <= ~cmpv;
      end
      rd(8'h02, 8'h20, 8'h00);
      wrr(8'h02, 8'h20);
      @(posedge clk_sys);
      cmpv <= 1'b1;
      tick(DLY + 3);
      cmp(wakes[7:0], 8'h01);
      @(posedge clk_sys);
      cmpv <= 1'b0;
      @(posedge clk_sys);
      sleep <= 1'b1;
      tick(0);
      cmp({7'h00, pwr}, 8'h00);
      @(posedge clk_sys);
      sleep <= 1'b0;
      low_voltage_reset <= 1'b0;
      idle <= 1'b0;
      wrr(8'h00, 8'h00);
      tick(0);
      cmp({7'h00, bg}, 8'h00);
   endtask
   task t_service;
      wrr(8'h02, 8'h03);
      full <= 1'b1;
      therm <= 1'b1;
      @(posedge clk_sys);
      therm <= 1'b0;
      tick(2);
      cmp({7'h00, req}, 8'h00);
      @(posedge clk_sys);
      full <= 1'b0;
      ack_on <= 1'b1;
      tick(0);
      cmp({3'h0, req, vec}, 8'h11);
      tick(6);
      rd(8'h02, 8'hff, 8'h02);
      wrr(8'h02, 8'h12);
      tick(0);
      cmp({7'h00, req}, 8'h00);
      @(posedge clk_sys);
      evts <= 10'h39f;
      @(posedge clk_sys);
      evts <= 10'h000;
      rd(8'h05, 8'hff, 8'h30);
      rd(8'h06, 8'hff, 8'h70);
      rd(8'h04, 8'hf0, 8'hf0);
      rd(8'h03, 8'h80, 8'h80);
   endtask
   task print_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs;
      t_edges;
      t_lowvolt;
      t_service;
      print_verdict;
   end
endmodule
